// file: core/epi_ahb_slave.sv
// AHB-Lite slave front end, zero wait states
`timescale 1ns/1ns
`default_nettype none
module epi_ahb_slave
  import epi_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] rd_data_in,
  output logic [7:0] rd_index_out,
  output epi_wr_s wr_out,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic [1:0] hresp_out
);
  logic pend_wr;
  logic [7:0] pend_index;
  logic next_pend_wr;
  logic [7:0] next_pend_index;
  logic [31:0] next_hrdata;
  logic addr_phase;
  logic mapped;

  assign addr_phase = hsel_in && hready_in && htrans_in[1];
  assign mapped = (haddr_in[31:10] == '0) && (haddr_in[1:0] == 2'h0);
  assign rd_index_out = haddr_in[9:2];

  always_comb begin
    next_pend_wr = 1'b0;
    next_pend_index = pend_index;
    next_hrdata = hrdata_out;
    if (addr_phase) begin
      next_pend_index = haddr_in[9:2];
      next_pend_wr = hwrite_in && mapped && (hsize_in == EPI_HSIZE_WORD);
      next_hrdata = (!hwrite_in && mapped) ? rd_data_in : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_wr <= 1'b0;
      pend_index <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= EPI_HRESP_OKAY;
    end else begin
      pend_wr <= next_pend_wr;
      pend_index <= next_pend_index;
      hrdata_out <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out <= EPI_HRESP_OKAY;
    end
  end

  // Write data arrives in the data phase
  assign wr_out.valid = pend_wr;
  assign wr_out.index = pend_index;
  assign wr_out.data = hwdata_in;
endmodule : epi_ahb_slave
`default_nettype wire

// file: core/epi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module epi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  initial begin
    if (WIDTH < 1) begin
      $error("epi_sync width must be positive");
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;
endmodule : epi_sync
`default_nettype wire

// file: core/epi_top.sv
// External pin interrupt unit top level
`timescale 1ns/1ns
`default_nettype none
// Function
// [R01] Dedicated pin request needs global enable and its own mask bit.
// [R02] Sense field: 00 low, 01 any change, 10 falling, 11 rising.
// [R03] Pin sampled before edge detect; pulses over one clock register.
// [R04] Driver keeps pin low until current instruction ends in level mode.
// [R05] Mask bit 6 enables dedicated pin; served by its own vector.
// [R06] Pins trigger even when driven as outputs by the device.
// [R07] Mask bit 5 with global enable enables group 1 pins 11..8.
// [R08] Mask bit 4 with global enable enables group 0 pins 7..0.
// [R09] Dedicated pin edge sets flag bit 6; vectors only when enabled.
// [R10] Flags clear on vector entry or by writing one.
// [R11] Dedicated pin flag held clear in low-level mode.
// [R12] Group 1 change sets flag bit 5.
// [R13] Group 0 change sets flag bit 4.
// [R14] High pin mask bits 3:0 enable pins 11..8 individually.
// [R15] Low pin mask bits 7:0 enable pins 7..0 individually.
// [R16] Reserved bits of mask, flag and high pin mask read zero.
// [R17] Pin changes also raise a wake indication for sleep logic.
// [R18] Edge modes need the clock; low level also signals wake.
// [R19] Vectors: dedicated 0x0001, group 0 0x0002, group 1 0x0003.
// [R20] Per pin: current xor previous, and mask, ored over group.
module epi_top
  import epi_pkg::*;
#(
  parameter int G0_PINS = EPI_G0_PINS,
  parameter int G1_PINS = EPI_G1_PINS
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic [1:0] hresp_out,
  input wire logic ext_irq_pin_in,
  input wire logic [G0_PINS-1:0] group0_change_inputs_in,
  input wire logic [G1_PINS-1:0] group1_change_inputs_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_ack_in,
  output logic irq_request_out,
  output logic [15:0] irq_vector_out,
  output logic wake_out
);
  localparam int NPINS = 1 + G0_PINS + G1_PINS;

  initial begin
    if (G0_PINS < 1 || G0_PINS > 8 || G1_PINS < 1 || G1_PINS > 4) begin
      $error("epi_top pin group sizes out of range");
    end
  end

  logic [NPINS-1:0] pins_sync;
  logic [NPINS-1:0] pins_prev;
  logic ext_s;
  logic ext_p;
  logic [G0_PINS-1:0] g0_s;
  logic [G0_PINS-1:0] g0_p;
  logic [G1_PINS-1:0] g1_s;
  logic [G1_PINS-1:0] g1_p;
  logic [G0_PINS-1:0] g0_hit;
  logic [G1_PINS-1:0] g1_hit;

  logic [7:0] pin_change_mask_low;
  logic [7:0] pin_change_mask_high;
  logic [7:0] interrupt_flag_reg;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] core_control_reg;
  logic [7:0] next_pin_change_mask_low;
  logic [7:0] next_pin_change_mask_high;
  logic [7:0] next_interrupt_flag_reg;
  logic [7:0] next_interrupt_mask_reg;
  logic [7:0] next_core_control_reg;
  logic next_irq_request;
  logic [15:0] next_irq_vector;
  logic next_wake;

  epi_wr_s wr;
  logic [7:0] rd_index;
  logic [31:0] rd_data;
  epi_sense_e sense;
  logic ext_trig;
  logic level_mode;
  epi_src_s set;
  epi_src_s req;
  logic [7:0] clr;

  epi_ahb_slave u_bus (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .rd_data_in(rd_data),
    .rd_index_out(rd_index),
    .wr_out(wr),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out)
  );

  // Raw pin levels, whatever the port direction
  epi_sync #(
    .WIDTH(NPINS)
  ) u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .async_in({ext_irq_pin_in, group1_change_inputs_in, group0_change_inputs_in}), // [R06] [R03]
    .sync_out(pins_sync)
  );

  assign {ext_s, g1_s, g0_s} = pins_sync;
  assign {ext_p, g1_p, g0_p} = pins_prev;

  // Per-pin change detection
  genvar gi;
  generate
    for (gi = 0; gi < G0_PINS; gi++) begin : g_grp0
      assign g0_hit[gi] = (g0_s[gi] ^ g0_p[gi]) & pin_change_mask_low[gi]; // [R20] [R15]
    end
    for (gi = 0; gi < G1_PINS; gi++) begin : g_grp1
      assign g1_hit[gi] = (g1_s[gi] ^ g1_p[gi]) & pin_change_mask_high[gi]; // [R20] [R14]
    end
  endgenerate

  assign sense = epi_sense_e'(core_control_reg[EPI_SENSE_LSB +: 2]);
  assign level_mode = (sense == EPI_SENSE_LOW);

  // Dedicated pin trigger selection
  always_comb begin
    case (sense) // [R02]
      EPI_SENSE_ANY: ext_trig = ext_s ^ ext_p;
      EPI_SENSE_FALL: ext_trig = ext_p & ~ext_s;
      EPI_SENSE_RISE: ext_trig = ext_s & ~ext_p;
      default: ext_trig = 1'b0;
    endcase
  end

  assign set.ext = ext_trig; // [R09]
  assign set.g1 = |g1_hit; // [R12]
  assign set.g0 = |g0_hit; // [R13]

  // Level request follows the pin directly and is not latched
  assign req.ext = global_irq_enable_in && interrupt_mask_reg[EPI_BIT_EXT] &&
                   (level_mode ? ~ext_s : interrupt_flag_reg[EPI_BIT_EXT]); // [R01] [R05] [R04] [R09]
  assign req.g1 = global_irq_enable_in && interrupt_mask_reg[EPI_BIT_G1] && interrupt_flag_reg[EPI_BIT_G1]; // [R07]
  assign req.g0 = global_irq_enable_in && interrupt_mask_reg[EPI_BIT_G0] && interrupt_flag_reg[EPI_BIT_G0]; // [R08]

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_index) // [R16]
      EPI_IDX_PCM_LOW: rd_data[7:0] = pin_change_mask_low & EPI_PCM_LOW_RW;
      EPI_IDX_PCM_HIGH: rd_data[7:0] = pin_change_mask_high & EPI_PCM_HIGH_RW;
      EPI_IDX_CORE_CTRL: rd_data[7:0] = core_control_reg & EPI_CORE_CTRL_RW;
      EPI_IDX_FLAG: rd_data[7:0] = interrupt_flag_reg & EPI_FLAG_RW;
      EPI_IDX_MASK: rd_data[7:0] = interrupt_mask_reg & EPI_MASK_RW;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Register and flag next state
  always_comb begin
    next_pin_change_mask_low = pin_change_mask_low;
    next_pin_change_mask_high = pin_change_mask_high;
    next_interrupt_mask_reg = interrupt_mask_reg;
    next_core_control_reg = core_control_reg;
    clr = 8'h00;
    if (wr.valid) begin
      case (wr.index)
        EPI_IDX_PCM_LOW: next_pin_change_mask_low = wr.data[7:0] & EPI_PCM_LOW_RW;
        EPI_IDX_PCM_HIGH: next_pin_change_mask_high = wr.data[7:0] & EPI_PCM_HIGH_RW; // [R16]
        EPI_IDX_CORE_CTRL: next_core_control_reg = wr.data[7:0] & EPI_CORE_CTRL_RW;
        EPI_IDX_FLAG: clr = wr.data[7:0] & EPI_FLAG_RW; // [R10]
        EPI_IDX_MASK: next_interrupt_mask_reg = wr.data[7:0] & EPI_MASK_RW; // [R16]
        default: clr = 8'h00;
      endcase
    end
    if (irq_ack_in && irq_request_out) begin
      case (irq_vector_out) // [R10]
        EPI_VEC_EXT: clr[EPI_BIT_EXT] = 1'b1;
        EPI_VEC_G0: clr[EPI_BIT_G0] = 1'b1;
        EPI_VEC_G1: clr[EPI_BIT_G1] = 1'b1;
        default: clr = clr;
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_interrupt_flag_reg = interrupt_flag_reg & ~clr;
    next_interrupt_flag_reg[EPI_BIT_EXT] = next_interrupt_flag_reg[EPI_BIT_EXT] | set.ext;
    next_interrupt_flag_reg[EPI_BIT_G1] = next_interrupt_flag_reg[EPI_BIT_G1] | set.g1;
    next_interrupt_flag_reg[EPI_BIT_G0] = next_interrupt_flag_reg[EPI_BIT_G0] | set.g0;
    next_interrupt_flag_reg = next_interrupt_flag_reg & EPI_FLAG_RW;
    if (level_mode) begin
      next_interrupt_flag_reg[EPI_BIT_EXT] = 1'b0; // [R11]
    end
    next_irq_request = req.ext | req.g0 | req.g1;
    next_irq_vector = epi_vector(req); // [R19] [R05]
    next_wake = (set.g0 & interrupt_mask_reg[EPI_BIT_G0]) | (set.g1 & interrupt_mask_reg[EPI_BIT_G1]) | // [R17]
                (level_mode & ~ext_s & interrupt_mask_reg[EPI_BIT_EXT]); // [R18]
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_prev <= '0;
      pin_change_mask_low <= EPI_RST_PCM_LOW;
      pin_change_mask_high <= EPI_RST_PCM_HIGH;
      interrupt_flag_reg <= EPI_RST_FLAG;
      interrupt_mask_reg <= EPI_RST_MASK;
      core_control_reg <= EPI_RST_CORE_CTRL;
      irq_request_out <= 1'b0;
      irq_vector_out <= EPI_VEC_NONE;
      wake_out <= 1'b0;
    end else begin
      pins_prev <= pins_sync;
      pin_change_mask_low <= next_pin_change_mask_low;
      pin_change_mask_high <= next_pin_change_mask_high;
      interrupt_flag_reg <= next_interrupt_flag_reg;
      interrupt_mask_reg <= next_interrupt_mask_reg;
      core_control_reg <= next_core_control_reg;
      irq_request_out <= next_irq_request;
      irq_vector_out <= next_irq_vector;
      wake_out <= next_wake;
    end
  end

  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  a_sync_two_stage: assert property (##2 (ext_s == $past(ext_irq_pin_in, 2))) // [R03]
    else $error("dedicated pin not delayed by two flops");
  a_rise_sets_flag: assert property ((sense == EPI_SENSE_RISE && ext_s && !ext_p) |=> interrupt_flag_reg[EPI_BIT_EXT]) // [R02]
    else $error("rising edge did not set flag");
  a_fall_no_flag: assert property ((sense == EPI_SENSE_FALL && !ext_p && !interrupt_flag_reg[EPI_BIT_EXT])
                                   |=> !interrupt_flag_reg[EPI_BIT_EXT]) // [R09]
    else $error("flag set without falling edge");
  a_level_flag_clear: assert property (level_mode |=> !interrupt_flag_reg[EPI_BIT_EXT]) // [R11]
    else $error("flag not held clear in level mode");
  a_ext_gated: assert property ((irq_request_out && irq_vector_out == EPI_VEC_EXT)
                                |-> $past(global_irq_enable_in && interrupt_mask_reg[EPI_BIT_EXT])) // [R01]
    else $error("dedicated request without enables");
  a_ext_vector: assert property (req.ext |=> irq_request_out && irq_vector_out == EPI_VEC_EXT) // [R05]
    else $error("dedicated request not on its vector");
  a_g0_vector: assert property ((req.g0 && !req.ext) |=> irq_vector_out == EPI_VEC_G0) // [R19]
    else $error("group 0 vector wrong");
  a_g1_gated: assert property ((irq_request_out && irq_vector_out == EPI_VEC_G1)
                               |-> $past(global_irq_enable_in && interrupt_mask_reg[EPI_BIT_G1])) // [R07]
    else $error("group 1 request without enables");
  a_g0_gated: assert property ((irq_request_out && irq_vector_out == EPI_VEC_G0)
                               |-> $past(global_irq_enable_in && interrupt_mask_reg[EPI_BIT_G0])) // [R08]
    else $error("group 0 request without enables");
  a_g0_sets_flag: assert property ((|g0_hit) |=> interrupt_flag_reg[EPI_BIT_G0]) // [R13]
    else $error("group 0 change lost");
  a_g1_sets_flag: assert property ((|g1_hit) |=> interrupt_flag_reg[EPI_BIT_G1]) // [R12]
    else $error("group 1 change lost");
  a_w1c_clear: assert property ((wr.valid && wr.index == EPI_IDX_FLAG && wr.data[EPI_BIT_G0] && !set.g0)
                                |=> !interrupt_flag_reg[EPI_BIT_G0]) // [R10]
    else $error("write one did not clear flag");
  a_ack_clear: assert property ((irq_ack_in && irq_request_out && irq_vector_out == EPI_VEC_G1 && !set.g1)
                                |=> !interrupt_flag_reg[EPI_BIT_G1]) // [R10]
    else $error("vector entry did not clear flag");
  a_masked_pins: assert property ((pin_change_mask_high == 8'h00) |-> !(|g1_hit)) // [R14]
    else $error("disabled pin detected");
  a_reserved_zero: assert property (((interrupt_mask_reg | interrupt_flag_reg) & ~EPI_MASK_RW) == 8'h00 &&
                                    (pin_change_mask_high & ~EPI_PCM_HIGH_RW) == 8'h00) // [R16]
    else $error("reserved bits set");
  a_any_sets_flag: assert property ((sense == EPI_SENSE_ANY && (ext_s != ext_p))
                                    |=> interrupt_flag_reg[EPI_BIT_EXT]) // [R02]
    else $error("pin change did not set flag");
  a_g0_no_change: assert property ((!interrupt_flag_reg[EPI_BIT_G0] && !(|g0_hit))
                                   |=> !interrupt_flag_reg[EPI_BIT_G0]) // [R15]
    else $error("group 0 flag set without change");
  a_wake_level: assert property ((level_mode && !ext_s && interrupt_mask_reg[EPI_BIT_EXT]) |=> wake_out) // [R18]
    else $error("level wake missing");
  a_wake_change: assert property ((set.g0 && interrupt_mask_reg[EPI_BIT_G0]) |=> wake_out) // [R17]
    else $error("pin change wake missing");

  c_ext_request: cover property (req.ext ##1 irq_request_out ##1 irq_ack_in);
  c_g0_request: cover property ((|g0_hit) ##1 req.g0);
  c_g1_request: cover property ((|g1_hit) ##1 req.g1);
  c_level_request: cover property (level_mode && req.ext);
  c_level_wake: cover property (level_mode && wake_out);
endmodule : epi_top
`default_nettype wire

// file: shared/epi_pkg.sv
// Shared constants and types of the external pin interrupt unit
package epi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] EPI_IDX_PCM_LOW = 8'h12;
  localparam logic [7:0] EPI_IDX_PCM_HIGH = 8'h20;
  localparam logic [7:0] EPI_IDX_CORE_CTRL = 8'h35;
  localparam logic [7:0] EPI_IDX_FLAG = 8'h3a;
  localparam logic [7:0] EPI_IDX_MASK = 8'h3b;

  // Field positions in mask, flag and core control registers
  localparam int EPI_BIT_EXT = 6;
  localparam int EPI_BIT_G1 = 5;
  localparam int EPI_BIT_G0 = 4;
  localparam int EPI_SENSE_LSB = 0;

  // Writable bits of each register; others read as zero
  localparam logic [7:0] EPI_PCM_LOW_RW = 8'hff;
  localparam logic [7:0] EPI_PCM_HIGH_RW = 8'h0f;
  localparam logic [7:0] EPI_CORE_CTRL_RW = 8'h03;
  localparam logic [7:0] EPI_FLAG_RW = 8'h70;
  localparam logic [7:0] EPI_MASK_RW = 8'h70;

  // Reset values
  localparam logic [7:0] EPI_RST_PCM_LOW = 8'h00;
  localparam logic [7:0] EPI_RST_PCM_HIGH = 8'h00;
  localparam logic [7:0] EPI_RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] EPI_RST_FLAG = 8'h00;
  localparam logic [7:0] EPI_RST_MASK = 8'h00;

  // Vector addresses
  localparam logic [15:0] EPI_VEC_NONE = 16'h0000;
  localparam logic [15:0] EPI_VEC_EXT = 16'h0001;
  localparam logic [15:0] EPI_VEC_G0 = 16'h0002;
  localparam logic [15:0] EPI_VEC_G1 = 16'h0003;

  // Pin group sizes
  localparam int EPI_G0_PINS = 8;
  localparam int EPI_G1_PINS = 4;

  // AHB-Lite codes
  localparam logic [2:0] EPI_HSIZE_WORD = 3'h2;
  localparam logic [1:0] EPI_HRESP_OKAY = 2'h0;

  typedef enum logic [1:0] {
    EPI_SENSE_LOW,
    EPI_SENSE_ANY,
    EPI_SENSE_FALL,
    EPI_SENSE_RISE
  } epi_sense_e;

  typedef struct packed {
    logic ext;
    logic g1;
    logic g0;
  } epi_src_s;

  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic [31:0] data;
  } epi_wr_s;

  // Fixed priority: dedicated pin, then group 0, then group 1
  function automatic logic [15:0] epi_vector(input epi_src_s req);
    if (req.ext) begin
      return EPI_VEC_EXT;
    end else if (req.g0) begin
      return EPI_VEC_G0;
    end else if (req.g1) begin
      return EPI_VEC_G1;
    end
    return EPI_VEC_NONE;
  endfunction : epi_vector

endpackage : epi_pkg

// file: verif/epi_pin_model.sv
// Model of the external port pins feeding the interrupt inputs
`timescale 1ns/1ns
`default_nettype none
module epi_pin_model (
  input wire logic clock_in,
  output logic ext_pin_out,
  output logic [7:0] group0_out,
  output logic [3:0] group1_out
);
  initial begin
    ext_pin_out = 1'b0;
    group0_out = 8'h00;
    group1_out = 4'h0;
  end

  // Dedicated pin level, held well past one clock and the current instruction
  task automatic ext_to(input logic level);
    @(posedge clock_in);
    ext_pin_out <= level;
    repeat (5) @(posedge clock_in);
  endtask : ext_to

  // Pin change inputs, held for several clocks
  task automatic groups_to(input logic [7:0] g0, input logic [3:0] g1);
    @(posedge clock_in);
    group0_out <= g0;
    group1_out <= g1;
    repeat (5) @(posedge clock_in);
  endtask : groups_to
endmodule : epi_pin_model
`default_nettype wire

// file: verif/external_pin_interrupt_unit_tb.sv
// Self-checking testbench of the external pin interrupt unit
`timescale 1ns/1ns
`default_nettype none
module external_pin_interrupt_unit_tb
  import epi_pkg::*;
;
  logic clock_in;
  logic nrst_in;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  wire logic hready;
  logic [1:0] hresp;
  logic ext_pin;
  logic [7:0] g0;
  logic [3:0] g1;
  logic gie;
  logic ack;
  logic req;
  logic [15:0] vec;
  logic wake;
  int error_cnt;
  int checks_done;
  int cyc = 0;

  epi_top epi_top_inst (
    .clock_in(clock_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ext_irq_pin_in(ext_pin), .group0_change_inputs_in(g0), .group1_change_inputs_in(g1),
    .global_irq_enable_in(gie), .irq_ack_in(ack), .irq_request_out(req),
    .irq_vector_out(vec), .wake_out(wake)
  );

  epi_pin_model epi_pin_model_inst (
    .clock_in(clock_in), .ext_pin_out(ext_pin), .group0_out(g0), .group1_out(g1)
  );

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One single word transfer on the bus
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    hsize <= EPI_HSIZE_WORD;
    do @(posedge clock_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock_in); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {30'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, {24'h0, d}, rd);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk(what, rd, {24'h0, exp});
  endtask : rd_chk

  task automatic irq_chk(input logic r, input logic [15:0] v);
    repeat (2) @(posedge clock_in);
    chk("irq_request", {31'h0, req}, {31'h0, r});
    if (r) chk("irq_vector", {16'h0, vec}, {16'h0, v});
  endtask : irq_chk

  task automatic ack_pulse;
    @(posedge clock_in);
    ack <= 1'b1;
    @(posedge clock_in);
    ack <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask : ack_pulse

  // Reset values, reserved bits and an unmapped address
  task automatic t_regs;
    rd_chk("pcm_low", EPI_IDX_PCM_LOW, 8'h00);
    rd_chk("pcm_high", EPI_IDX_PCM_HIGH, 8'h00);
    rd_chk("flag", EPI_IDX_FLAG, 8'h00);
    rd_chk("mask", EPI_IDX_MASK, 8'h00);
    rd_chk("sense", EPI_IDX_CORE_CTRL, 8'h00);
    wr(EPI_IDX_PCM_LOW, 8'hff);
    rd_chk("pcm_low", EPI_IDX_PCM_LOW, 8'hff);
    wr(EPI_IDX_PCM_HIGH, 8'hff);
    rd_chk("pcm_high", EPI_IDX_PCM_HIGH, 8'h0f);
    wr(EPI_IDX_MASK, 8'h8f);
    rd_chk("mask", EPI_IDX_MASK, 8'h00);
    wr(EPI_IDX_FLAG, 8'hff);
    rd_chk("flag", EPI_IDX_FLAG, 8'h00);
    wr(8'h00, 8'hff);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr(EPI_IDX_PCM_LOW, 8'h00);
    wr(EPI_IDX_PCM_HIGH, 8'h00);
  endtask : t_regs

  // Group 0: masked pin ignored, flag without enable, request and ack
  task automatic t_group0;
    wr(EPI_IDX_PCM_LOW, 8'h01);
    epi_pin_model_inst.groups_to(8'h02, 4'h0);
    rd_chk("g0 masked", EPI_IDX_FLAG, 8'h00);
    epi_pin_model_inst.groups_to(8'h03, 4'h0);
    rd_chk("g0 flag", EPI_IDX_FLAG, 8'h10);
    irq_chk(1'b0, 16'h0000);
    gie <= 1'b1;
    wr(EPI_IDX_MASK, 8'h10);
    irq_chk(1'b1, 16'h0002);
    ack_pulse();
    rd_chk("g0 ack", EPI_IDX_FLAG, 8'h00);
    irq_chk(1'b0, 16'h0000);
    gie <= 1'b0;
    wr(EPI_IDX_PCM_LOW, 8'h00);
    wr(EPI_IDX_MASK, 8'h00);
  endtask : t_group0

  // Group 1: per-pin mask, global enable gating, write-one clear
  task automatic t_group1;
    wr(EPI_IDX_PCM_HIGH, 8'h08);
    gie <= 1'b1;
    wr(EPI_IDX_MASK, 8'h20);
    epi_pin_model_inst.groups_to(8'h03, 4'h7);
    rd_chk("g1 masked", EPI_IDX_FLAG, 8'h00);
    epi_pin_model_inst.groups_to(8'h03, 4'hf);
    irq_chk(1'b1, 16'h0003);
    rd_chk("g1 flag", EPI_IDX_FLAG, 8'h20);
    gie <= 1'b0;
    irq_chk(1'b0, 16'h0000);
    wr(EPI_IDX_FLAG, 8'h20);
    rd_chk("g1 clear", EPI_IDX_FLAG, 8'h00);
    wr(EPI_IDX_PCM_HIGH, 8'h00);
    wr(EPI_IDX_MASK, 8'h00);
  endtask : t_group1

  // Dedicated pin in every sense mode
  task automatic t_ext;
    for (int m = 1; m < 4; m++) begin
      wr(EPI_IDX_CORE_CTRL, 8'(m));
      wr(EPI_IDX_FLAG, 8'h40);
      epi_pin_model_inst.ext_to(1'b1);
      rd_chk("ext rise", EPI_IDX_FLAG, (m != 2) ? 8'h40 : 8'h00);
      irq_chk(1'b0, 16'h0000);
      wr(EPI_IDX_FLAG, 8'h40);
      epi_pin_model_inst.ext_to(1'b0);
      rd_chk("ext fall", EPI_IDX_FLAG, (m != 3) ? 8'h40 : 8'h00);
    end
    wr(EPI_IDX_CORE_CTRL, 8'h00);
    wr(EPI_IDX_FLAG, 8'h40);
    rd_chk("ext level", EPI_IDX_FLAG, 8'h00);
    gie <= 1'b1;
    wr(EPI_IDX_MASK, 8'h40);
    irq_chk(1'b1, 16'h0001);
    chk("wake level", {31'h0, wake}, 32'h1);
    gie <= 1'b0;
    irq_chk(1'b0, 16'h0000);
    gie <= 1'b1;
    epi_pin_model_inst.ext_to(1'b1);
    irq_chk(1'b0, 16'h0000);
    chk("wake high", {31'h0, wake}, 32'h0);
    rd_chk("ext level high", EPI_IDX_FLAG, 8'h00);
    gie <= 1'b0;
    wr(EPI_IDX_MASK, 8'h00);
  endtask : t_ext

  task automatic test_done;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Cut a hang short
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    nrst_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = EPI_HSIZE_WORD;
    hwdata = 32'h0;
    gie = 1'b0;
    ack = 1'b0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_regs();
    t_group0();
    t_group1();
    t_ext();
    test_done();
  end
endmodule : external_pin_interrupt_unit_tb
`default_nettype wire
